// File: core/tcpu_pkg.sv
// Package with trap classes, identifiers, priorities and register map.
`default_nettype none
package tcpu_pkg;
	localparam logic [2:0] class_ctx = 3'h3;
	localparam logic [2:0] class_bus = 3'h4;
	localparam logic [2:0] class_assert = 3'h5;
	localparam logic [2:0] class_sys = 3'h6;
	localparam logic [2:0] class_nmi = 3'h7;
	localparam logic [7:0] tin_nmi = 8'h00;
	localparam logic [7:0] tin_fetch_sync = 8'h01;
	localparam logic [7:0] tin_data_sync = 8'h02;
	localparam logic [7:0] tin_data_async = 8'h03;
	localparam logic [7:0] tin_coproc = 8'h04;
	localparam logic [7:0] tin_prog_integ = 8'h05;
	localparam logic [7:0] tin_data_integ = 8'h06;
	localparam logic [7:0] tin_temporal = 8'h07;
	localparam logic [7:0] tin_overflow = 8'h01;
	localparam logic [7:0] tin_sticky_ovf = 8'h02;
	localparam logic [7:0] tin_ctx_underflow = 8'h04;
	localparam int class_shift = 5;
	localparam int sync_count = 32;
	localparam logic [31:0] spad_win_base = 32'hd0000000;
	localparam logic [31:0] spad_win_last = 32'hd3ffffff;
	localparam logic [31:0] spad_size_rst = 32'h00010000;
	localparam logic [31:0] vec_base_rst = 32'ha0000100;
	localparam logic [5:0] prio_vfetch = 6'h02;
	localparam logic [5:0] prio_fetch_ap = 6'h03;
	localparam logic [5:0] prio_fetch_bus = 6'h05;
	localparam logic [5:0] prio_prog_integ = 6'h06;
	localparam logic [5:0] prio_system_call_instr = 6'h0d;
	localparam logic [5:0] prio_data_bus = 6'h1d;
	localparam logic [5:0] prio_sticky_ovf = 6'h1e;
	localparam logic [5:0] prio_overflow = 6'h1f;
	localparam logic [7:0] reg_vec_base = 8'h00;
	localparam logic [7:0] reg_ctrl = 8'h04;
	localparam logic [7:0] reg_spad_size = 8'h08;
	localparam logic [7:0] reg_status = 8'h0c;
	localparam logic [7:0] reg_vector = 8'h10;
	localparam int ctrl_mmu_en = 0;
	localparam int ctrl_die_async = 1;
	typedef enum logic [1:0] {tcpu_none_t_v, tcpu_async_v, tcpu_sync_v,
		tcpu_irq_v} tcpu_kind_t;
endpackage
`default_nettype wire

// File: core/tcpu_trap_unit.sv
// Trap cause detection and exception priority resolution.
`timescale 1ns/1ps
`default_nettype none
//
// Overview of operation
// - Fetch bus or no-code segment raises class4 id1.
// - Load bus, scratchpad overrun, refill error: id2.
// - Store, cache op, writeback errors: id3.
// - Any coprocessor error gives shared id4.
// - Fetch group uncorrectable error gives id5.
// - Data uncorrectable error gives id6, configurable.
// - Fetch in scratchpad window beyond memory: bus error.
// - Temporal timer reaching zero gives id7.
// - Overflow trap instruction with flag: class5 id1.
// - Sticky overflow instruction with flag: class5 id2.
// - System call loads immediate as identifier.
// - Non-maskable interrupt uses identifier zero.
// - Debug traps bypass vector and identifier scheme.
// - Async over sync over interrupt.
// - Older instruction wins; younger traps discarded.
// - Null free context on save outranks all.
// - Fetch causes rank first, priorities 1 to 6.
// - Format then instruction traps, 7 to 13.
// - Context traps rank 14 to 20.
// - Data access 21-29, then 30, 31, 32.
// - Fetch MMU causes only with MMU enabled.
// - Async order: nmi, data, coproc, temporal, integrity.
// - Vector is base ORed with class shifted five.
//
module tcpu_trap_unit #(
	parameter int coproc_count = 4
)(
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic [31:0] wb_adr_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic wb_we_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	output logic wb_err_o,
	input wire logic instr_valid,
	input wire logic older_trap_pending,
	input wire logic fetch_valid,
	input wire logic [31:0] fetch_addr,
	input wire logic fetch_bus_error,
	input wire logic fetch_no_code_attr,
	input wire logic fetch_group_ecc_error,
	input wire logic data_load_bus_error,
	input wire logic data_access_valid,
	input wire logic [31:0] data_addr,
	input wire logic cache_refill_error,
	input wire logic data_store_bus_error,
	input wire logic cache_mgmt_error,
	input wire logic cache_writeback_error,
	input wire logic data_ecc_error,
	input wire logic [coproc_count-1:0] coproc_error,
	input wire logic temporal_timer_zero,
	input wire logic nmi_request,
	input wire logic trap_on_overflow_instr,
	input wire logic trap_on_sticky_overflow_instr,
	input wire logic status_overflow_flag,
	input wire logic status_sticky_overflow_flag,
	input wire logic system_call_instr,
	input wire logic [7:0] system_call_imm,
	input wire logic context_save_req,
	input wire logic [31:0] free_context_pointer,
	input wire logic [31:0] other_sync_causes,
	input wire logic debug_break_req,
	input wire logic irq_request,
	output logic trap_take,
	output logic [2:0] trap_class,
	output logic [7:0] trap_identifier,
	output logic [31:0] trap_vector,
	output logic [1:0] trap_kind,
	output logic d15_write,
	output logic [7:0] d15_value,
	output logic debug_trap,
	output logic irq_take
);
	// ------------------------------------------------------------
	// Configuration registers and bus slave.
	// ------------------------------------------------------------
	logic [31:0] vec_base_reg;
	logic [1:0] ctrl_reg;
	logic [31:0] spad_size_reg;
	logic [2:0] last_class_reg;
	logic [7:0] last_tin_reg;
	logic [31:0] last_vec_reg;
	logic wb_hit;
	logic wb_req;
	if (coproc_count < 1)
	begin
		$error("coproc_count must be at least one");
	end
	assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
	assign wb_hit = (wb_adr_i[31:8] == 24'h000000) && (wb_adr_i[1:0] == 2'h0)
		&& (wb_adr_i[7:0] <= tcpu_pkg::reg_vector);
	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			wb_ack_o <= 1'b0;
			wb_err_o <= 1'b0;
		end
		else
		begin
			wb_ack_o <= wb_req && wb_hit;
			wb_err_o <= wb_req && !wb_hit;
		end
	end
	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			vec_base_reg <= tcpu_pkg::vec_base_rst;
			ctrl_reg <= 2'h0;
			spad_size_reg <= tcpu_pkg::spad_size_rst;
		end
		else if (wb_ack_o && wb_cyc_i && wb_stb_i && wb_we_i)
		begin
			unique case (wb_adr_i[7:0])
				tcpu_pkg::reg_vec_base:
				begin
					for (int i = 0; i < 4; i++)
						if (wb_sel_i[i])
							vec_base_reg[i*8 +: 8] <= wb_dat_i[i*8 +: 8];
					vec_base_reg[0] <= 1'b0;
				end
				tcpu_pkg::reg_ctrl:
				begin
					if (wb_sel_i[0])
						ctrl_reg <= wb_dat_i[1:0];
				end
				tcpu_pkg::reg_spad_size:
				begin
					for (int i = 0; i < 4; i++)
						if (wb_sel_i[i])
							spad_size_reg[i*8 +: 8] <= wb_dat_i[i*8 +: 8];
				end
				default:
				begin
				end
			endcase
		end
	end
	always_ff @(posedge ref_clk)
	begin
		if (rst)
			wb_dat_o <= 32'h00000000;
		else if (wb_req && wb_hit && !wb_we_i)
		begin
			unique case (wb_adr_i[7:0])
				tcpu_pkg::reg_vec_base: wb_dat_o <= vec_base_reg;
				tcpu_pkg::reg_ctrl: wb_dat_o <= {30'h0, ctrl_reg};
				tcpu_pkg::reg_spad_size: wb_dat_o <= spad_size_reg;
				tcpu_pkg::reg_status: wb_dat_o <= {21'h0, last_class_reg,
					last_tin_reg};
				default: wb_dat_o <= last_vec_reg;
			endcase
		end
		else
			wb_dat_o <= 32'h00000000;
	end
	// ------------------------------------------------------------
	// Cause detection.
	// ------------------------------------------------------------
	logic mmu_on;
	logic die_async;
	logic fetch_spad_miss;
	logic data_spad_miss;
	logic fetch_sync_error;
	logic data_sync_error;
	logic data_async_error;
	logic coproc_async_error;
	logic program_integrity_error;
	logic data_integrity_error;
	logic temporal_async_error;
	logic overflow_assert_trap;
	logic sticky_overflow_assert_trap;
	logic system_call_trap;
	logic context_list_underflow;
	logic [32:1] sync_vec;
	assign mmu_on = ctrl_reg[tcpu_pkg::ctrl_mmu_en];
	assign die_async = ctrl_reg[tcpu_pkg::ctrl_die_async];
	function automatic logic spad_overrun(input logic [31:0] a,
		input logic [31:0] sz);
		logic [31:0] off;
		off = a - tcpu_pkg::spad_win_base;
		spad_overrun = (a >= tcpu_pkg::spad_win_base)
			&& (a <= tcpu_pkg::spad_win_last) && (off >= sz);
	endfunction
	assign fetch_spad_miss = fetch_valid && spad_overrun(fetch_addr,
		spad_size_reg);
	assign data_spad_miss = data_access_valid && spad_overrun(data_addr,
		spad_size_reg);
	assign fetch_sync_error = fetch_bus_error || fetch_no_code_attr
		|| fetch_spad_miss;
	assign data_sync_error = data_load_bus_error || data_spad_miss
		|| cache_refill_error;
	assign data_async_error = data_store_bus_error || cache_mgmt_error
		|| cache_writeback_error;
	assign coproc_async_error = |coproc_error;
	assign program_integrity_error = fetch_group_ecc_error;
	assign data_integrity_error = data_ecc_error;
	assign temporal_async_error = temporal_timer_zero;
	assign overflow_assert_trap = trap_on_overflow_instr
		&& status_overflow_flag;
	assign sticky_overflow_assert_trap = trap_on_sticky_overflow_instr
		&& status_sticky_overflow_flag;
	assign system_call_trap = system_call_instr;
	assign context_list_underflow = context_save_req
		&& (free_context_pointer == 32'h00000000);
	always_comb
	begin
		sync_vec = other_sync_causes;
		sync_vec[tcpu_pkg::prio_vfetch] = other_sync_causes[1]
			&& mmu_on;
		sync_vec[tcpu_pkg::prio_fetch_ap] = other_sync_causes[2]
			&& mmu_on;
		sync_vec[tcpu_pkg::prio_fetch_bus] = fetch_sync_error;
		sync_vec[tcpu_pkg::prio_prog_integ] = program_integrity_error;
		sync_vec[tcpu_pkg::prio_system_call_instr] = system_call_trap;
		sync_vec[tcpu_pkg::prio_data_bus] = data_sync_error
			|| (data_integrity_error && !die_async);
		sync_vec[tcpu_pkg::prio_sticky_ovf] = sticky_overflow_assert_trap;
		sync_vec[tcpu_pkg::prio_overflow] = overflow_assert_trap;
	end
	// ------------------------------------------------------------
	// Priority resolution.
	// ------------------------------------------------------------
	function automatic logic [5:0] first_set(input logic [32:1] v);
		first_set = 6'h00;
		for (int i = 32; i >= 1; i--)
			if (v[i])
				first_set = 6'(i);
	endfunction
	logic [5:0] sync_win;
	logic take_n;
	logic [2:0] class_n;
	logic [7:0] tin_n;
	logic [1:0] kind_n;
	logic d15_n;
	logic dbg_n;
	logic irq_n;
	logic sync_ok;
	assign sync_win = first_set(sync_vec);
	assign sync_ok = instr_valid && !older_trap_pending;
	always_comb
	begin
		take_n = 1'b1;
		class_n = tcpu_pkg::class_bus;
		tin_n = 8'h00;
		kind_n = 2'(tcpu_pkg::tcpu_async_v);
		d15_n = 1'b0;
		dbg_n = 1'b0;
		irq_n = 1'b0;
		if (context_list_underflow)
		begin
			class_n = tcpu_pkg::class_ctx;
			tin_n = tcpu_pkg::tin_ctx_underflow;
			d15_n = 1'b1;
		end
		else if (nmi_request)
		begin
			class_n = tcpu_pkg::class_nmi;
			tin_n = tcpu_pkg::tin_nmi;
		end
		else if (data_async_error)
			tin_n = tcpu_pkg::tin_data_async;
		else if (coproc_async_error)
			tin_n = tcpu_pkg::tin_coproc;
		else if (temporal_async_error)
			tin_n = tcpu_pkg::tin_temporal;
		else if (data_integrity_error && die_async)
			tin_n = tcpu_pkg::tin_data_integ;
		else if (sync_ok && (sync_win != 6'h00))
		begin
			kind_n = 2'(tcpu_pkg::tcpu_sync_v);
			unique case (sync_win)
				tcpu_pkg::prio_fetch_bus: tin_n = tcpu_pkg::tin_fetch_sync;
				tcpu_pkg::prio_prog_integ: tin_n = tcpu_pkg::tin_prog_integ;
				tcpu_pkg::prio_data_bus: tin_n = data_sync_error
					? tcpu_pkg::tin_data_sync : tcpu_pkg::tin_data_integ;
				tcpu_pkg::prio_system_call_instr:
				begin
					class_n = tcpu_pkg::class_sys;
					tin_n = system_call_imm;
					d15_n = 1'b1;
				end
				tcpu_pkg::prio_sticky_ovf:
				begin
					class_n = tcpu_pkg::class_assert;
					tin_n = tcpu_pkg::tin_sticky_ovf;
				end
				tcpu_pkg::prio_overflow:
				begin
					class_n = tcpu_pkg::class_assert;
					tin_n = tcpu_pkg::tin_overflow;
				end
				default:
				begin
					take_n = 1'b0;
					kind_n = 2'(tcpu_pkg::tcpu_none_t_v);
				end
			endcase
		end
		else if (sync_ok && debug_break_req)
		begin
			take_n = 1'b0;
			kind_n = 2'(tcpu_pkg::tcpu_none_t_v);
			dbg_n = 1'b1;
		end
		else
		begin
			take_n = 1'b0;
			irq_n = irq_request;
			kind_n = irq_request ? 2'(tcpu_pkg::tcpu_irq_v)
				: 2'(tcpu_pkg::tcpu_none_t_v);
		end
	end
	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			trap_take <= 1'b0;
			trap_class <= 3'h0;
			trap_identifier <= 8'h00;
			trap_vector <= 32'h00000000;
			trap_kind <= 2'h0;
			d15_write <= 1'b0;
			d15_value <= 8'h00;
			debug_trap <= 1'b0;
			irq_take <= 1'b0;
		end
		else
		begin
			trap_take <= take_n;
			trap_class <= class_n;
			trap_identifier <= tin_n;
			trap_vector <= vec_base_reg | (32'(class_n)
				<< tcpu_pkg::class_shift);
			trap_kind <= kind_n;
			d15_write <= take_n && d15_n;
			d15_value <= tin_n;
			debug_trap <= dbg_n;
			irq_take <= irq_n;
		end
	end
	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			last_class_reg <= 3'h0;
			last_tin_reg <= 8'h00;
			last_vec_reg <= 32'h00000000;
		end
		else if (trap_take)
		begin
			last_class_reg <= trap_class;
			last_tin_reg <= trap_identifier;
			last_vec_reg <= trap_vector;
		end
	end
	// ------------------------------------------------------------
	// Assertions.
	// ------------------------------------------------------------
	a_underflow_wins: assert property (@(posedge ref_clk) disable iff (rst)
		context_list_underflow |=> trap_take && trap_class == 3'h3
		&& trap_identifier == 8'h04)
		else $error("context underflow not taken first");
	a_nmi_id: assert property (@(posedge ref_clk) disable iff (rst)
		nmi_request && !context_list_underflow |=> trap_class == 3'h7
		&& trap_identifier == 8'h00)
		else $error("nmi identifier wrong");
	a_async_over_sync: assert property (@(posedge ref_clk) disable iff (rst)
		!context_list_underflow && !nmi_request && data_async_error
		|=> trap_identifier == 8'h03 && trap_kind == 2'h1)
		else $error("async order wrong");
	a_system_call_instr_tin: assert property (@(posedge ref_clk) disable iff (rst)
		trap_take && trap_class == 3'h6 |-> d15_write
		&& d15_value == $past(system_call_imm))
		else $error("system_call_instr identifier wrong");
	a_vector_form: assert property (@(posedge ref_clk) disable iff (rst)
		trap_take |-> trap_vector[7:5] == trap_class)
		else $error("vector address wrong");
	a_young_void: assert property (@(posedge ref_clk) disable iff (rst)
		older_trap_pending |=> trap_kind != 2'h2)
		else $error("younger sync trap taken");
	a_irq_lowest: assert property (@(posedge ref_clk) disable iff (rst)
		irq_take |-> !trap_take && !debug_trap)
		else $error("interrupt beat a trap");
	a_mmu_gate: assert property (@(posedge ref_clk) disable iff (rst)
		!mmu_on |-> !sync_vec[2] && !sync_vec[3])
		else $error("mmu fetch cause used while off");
	c_system_call_instr: cover property (@(posedge ref_clk) trap_take
		&& trap_class == 3'h6);
	c_nmi: cover property (@(posedge ref_clk) trap_take
		&& trap_class == 3'h7);
	c_irq: cover property (@(posedge ref_clk) irq_take);
endmodule
`default_nettype wire

// File: sim/tcpu_far_model.sv
// Far-side model of the store path, caches, coprocessors, timers and NMI.
`timescale 1ns/1ps
`default_nettype none
module tcpu_far_model #(
	parameter int coproc_count = 4
)(
	input wire logic [5:0] err_req,
	input wire logic [1:0] coproc_sel,
	output logic data_store_bus_error,
	output logic cache_mgmt_error,
	output logic cache_writeback_error,
	output logic [coproc_count-1:0] coproc_error,
	output logic temporal_timer_zero,
	output logic nmi_request
);
	always_comb
	begin
		data_store_bus_error = err_req[0];
		cache_mgmt_error = err_req[1];
		cache_writeback_error = err_req[2];
		coproc_error = '0;
		coproc_error[coproc_sel] = err_req[3];
		temporal_timer_zero = err_req[4];
		nmi_request = err_req[5];
	end
endmodule
`default_nettype wire

// File: sim/trap_cause_priority_unit_tb.sv
// Self-checking testbench of the trap cause and priority unit.
`timescale 1ns/1ps
`default_nettype none
module trap_cause_priority_unit_tb;
	logic ref_clk = 1'b0;
	logic rst = 1'b1;
	logic [31:0] wb_adr_i = '0, wb_dat_i = '0, fetch_addr = '0, data_addr = '0;
	logic [31:0] free_context_pointer = '0, other_sync_causes = '0;
	logic [31:0] vec_base_exp;
	logic [3:0] wb_sel_i = '0;
	logic wb_we_i = 0, wb_cyc_i = 0, wb_stb_i = 0, instr_valid = 0;
	logic older_trap_pending = 0, fetch_valid = 0, fetch_bus_error = 0;
	logic fetch_no_code_attr = 0, fetch_group_ecc_error = 0, irq_request = 0;
	logic data_load_bus_error = 0, data_access_valid = 0, cache_refill_error = 0;
	logic data_ecc_error = 0, trap_on_overflow_instr = 0, status_overflow_flag = 0;
	logic trap_on_sticky_overflow_instr = 0, status_sticky_overflow_flag = 0;
	logic system_call_instr = 0, context_save_req = 0, debug_break_req = 0;
	logic [7:0] system_call_imm = '0;
	logic [5:0] err_req = '0;
	logic [1:0] coproc_sel = '0;
	logic data_store_bus_error, cache_mgmt_error, cache_writeback_error;
	logic temporal_timer_zero, nmi_request, wb_ack_o, wb_err_o, trap_take;
	logic d15_write, debug_trap, irq_take;
	logic [3:0] coproc_error;
	logic [31:0] wb_dat_o, trap_vector;
	logic [2:0] trap_class;
	logic [7:0] trap_identifier, d15_value;
	logic [1:0] trap_kind;
	int miscompares = 0;
	int checks_done = 0;

	tcpu_far_model #(.coproc_count(4)) i_far (.err_req, .coproc_sel,
		.data_store_bus_error, .cache_mgmt_error, .cache_writeback_error,
		.coproc_error, .temporal_timer_zero, .nmi_request);

	tcpu_trap_unit #(.coproc_count(4)) i_dut (.ref_clk, .rst, .wb_adr_i,
		.wb_dat_i, .wb_sel_i, .wb_we_i, .wb_cyc_i, .wb_stb_i, .wb_dat_o,
		.wb_ack_o, .wb_err_o, .instr_valid, .older_trap_pending, .fetch_valid,
		.fetch_addr, .fetch_bus_error, .fetch_no_code_attr,
		.fetch_group_ecc_error, .data_load_bus_error, .data_access_valid,
		.data_addr, .cache_refill_error, .data_store_bus_error,
		.cache_mgmt_error, .cache_writeback_error, .data_ecc_error,
		.coproc_error, .temporal_timer_zero, .nmi_request,
		.trap_on_overflow_instr, .trap_on_sticky_overflow_instr,
		.status_overflow_flag, .status_sticky_overflow_flag, .system_call_instr,
		.system_call_imm, .context_save_req, .free_context_pointer,
		.other_sync_causes, .debug_break_req, .irq_request, .trap_take,
		.trap_class, .trap_identifier, .trap_vector, .trap_kind, .d15_write,
		.d15_value, .debug_trap, .irq_take);

	initial
	begin
		forever #2 ref_clk = ~ref_clk;
	end

	// ----------------------------------------------------------------
	// Shared tasks.
	// ----------------------------------------------------------------
	task automatic check(input string n, input logic [31:0] e,
		input logic [31:0] g);
		checks_done++;
		if (g !== e)
		begin
			miscompares++;
			$display("unexpected %s: expected %h seen %h", n, e, g);
		end
	endtask

	task tally_and_finish;
		$display("checks %0d mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	task clr;
		{fetch_valid, fetch_bus_error, fetch_no_code_attr} <= '0;
		{fetch_group_ecc_error, data_load_bus_error, data_access_valid} <= '0;
		{cache_refill_error, data_ecc_error, trap_on_overflow_instr} <= '0;
		{status_overflow_flag, trap_on_sticky_overflow_instr} <= '0;
		{status_sticky_overflow_flag, system_call_instr, context_save_req} <= '0;
		{older_trap_pending, debug_break_req, irq_request} <= '0;
		err_req <= '0;
		other_sync_causes <= '0;
		free_context_pointer <= 32'h00000100;
	endtask

	task automatic wb(input logic [31:0] a, input logic w, input logic [31:0] d,
		input logic [3:0] s, output logic [31:0] q, output logic e);
		int n;
		n = 0;
		@(posedge ref_clk);
		{wb_cyc_i, wb_stb_i, wb_we_i} <= {2'b11, w};
		{wb_adr_i, wb_dat_i, wb_sel_i} <= {a, d, s};
		do
		begin
			@(posedge ref_clk);
			n++;
		end
		while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1 && n < 40);
		check("bus answer", 32'h1, 32'(n < 40));
		q = wb_dat_o;
		e = wb_err_o;
		{wb_cyc_i, wb_stb_i, wb_we_i} <= 3'b000;
		@(posedge ref_clk);
	endtask

	task automatic expect_trap(input logic tk, input logic [2:0] c,
		input logic [7:0] t, input logic [1:0] k);
		@(posedge ref_clk);
		clr();
		#1;
		check("trap_take", 32'(tk), 32'(trap_take));
		if (tk)
		begin
			check("trap_class", 32'(c), 32'(trap_class));
			check("trap_identifier", 32'(t), 32'(trap_identifier));
			check("trap_vector", vec_base_exp | (32'(c) << 5), trap_vector);
			if (k != 2'h0)
				check("trap_kind", 32'(k), 32'(trap_kind));
		end
	endtask

	// ----------------------------------------------------------------
	// Scenarios.
	// ----------------------------------------------------------------
	task automatic t_regs;
		logic [31:0] q;
		logic e;
		check("trap_take", 32'h0, 32'(trap_take));
		wb(32'h0, 1'b0, 32'h0, 4'hf, q, e);
		check("vector base", 32'ha0000100, q);
		wb(32'h4, 1'b0, 32'h0, 4'hf, q, e);
		check("ctrl", 32'h0, q);
		wb(32'h8, 1'b0, 32'h0, 4'hf, q, e);
		check("scratchpad size", 32'h00010000, q);
		wb(32'h14, 1'b0, 32'h0, 4'hf, q, e);
		check("unmapped err", 32'h1, 32'(e));
		wb(32'h0, 1'b1, 32'hb0000301, 4'hf, q, e);
		wb(32'h0, 1'b0, 32'h0, 4'hf, q, e);
		check("vector base", 32'hb0000300, q);
		vec_base_exp = 32'hb0000300;
		$display("test registers done");
	endtask

	task automatic t_async;
		logic [47:0] tab;
		logic [31:0] q;
		logic e;
		tab = 48'h000704030303;
		for (int i = 0; i < 6; i++)
		begin
			@(posedge ref_clk);
			err_req <= 6'(1 << i);
			expect_trap(1'b1, (i == 5) ? 3'h7 : 3'h4, tab[8*i +: 8], 2'h1);
		end
		for (int i = 0; i < 4; i++)
		begin
			@(posedge ref_clk);
			coproc_sel <= 2'(i);
			err_req <= 6'h08;
			expect_trap(1'b1, 3'h4, 8'h04, 2'h1);
		end
		@(posedge ref_clk);
		err_req <= 6'h3f;
		expect_trap(1'b1, 3'h7, 8'h00, 2'h1);
		@(posedge ref_clk);
		err_req <= 6'h09;
		expect_trap(1'b1, 3'h4, 8'h03, 2'h1);
		@(posedge ref_clk);
		err_req <= 6'h18;
		expect_trap(1'b1, 3'h4, 8'h04, 2'h1);
		@(posedge ref_clk);
		err_req <= 6'h20;
		fetch_bus_error <= 1'b1;
		expect_trap(1'b1, 3'h7, 8'h00, 2'h1);
		wb(32'h4, 1'b1, 32'h2, 4'h1, q, e);
		@(posedge ref_clk);
		err_req <= 6'h10;
		data_ecc_error <= 1'b1;
		expect_trap(1'b1, 3'h4, 8'h07, 2'h1);
		@(posedge ref_clk);
		data_ecc_error <= 1'b1;
		expect_trap(1'b1, 3'h4, 8'h06, 2'h1);
		wb(32'h4, 1'b1, 32'h0, 4'h1, q, e);
		$display("test async done");
	endtask

	task automatic t_sync;
		@(posedge ref_clk);
		fetch_bus_error <= 1'b1;
		expect_trap(1'b1, 3'h4, 8'h01, 2'h2);
		@(posedge ref_clk);
		fetch_no_code_attr <= 1'b1;
		expect_trap(1'b1, 3'h4, 8'h01, 2'h2);
		@(posedge ref_clk);
		{fetch_valid, fetch_addr} <= {1'b1, 32'hd0010000};
		expect_trap(1'b1, 3'h4, 8'h01, 2'h2);
		@(posedge ref_clk);
		{fetch_valid, fetch_addr} <= {1'b1, 32'hd000fffc};
		expect_trap(1'b0, 3'h0, 8'h00, 2'h0);
		@(posedge ref_clk);
		data_load_bus_error <= 1'b1;
		expect_trap(1'b1, 3'h4, 8'h02, 2'h2);
		@(posedge ref_clk);
		{data_access_valid, data_addr} <= {1'b1, 32'hd0010000};
		expect_trap(1'b1, 3'h4, 8'h02, 2'h2);
		@(posedge ref_clk);
		cache_refill_error <= 1'b1;
		expect_trap(1'b1, 3'h4, 8'h02, 2'h2);
		@(posedge ref_clk);
		{fetch_group_ecc_error, fetch_bus_error} <= 2'b11;
		expect_trap(1'b1, 3'h4, 8'h01, 2'h2);
		@(posedge ref_clk);
		fetch_group_ecc_error <= 1'b1;
		other_sync_causes <= 32'h00000006;
		expect_trap(1'b1, 3'h4, 8'h05, 2'h2);
		@(posedge ref_clk);
		{fetch_group_ecc_error, other_sync_causes} <= {1'b1, 32'h00000008};
		expect_trap(1'b0, 3'h0, 8'h00, 2'h0);
		@(posedge ref_clk);
		data_load_bus_error <= 1'b1;
		other_sync_causes <= 32'h00002000;
		expect_trap(1'b0, 3'h0, 8'h00, 2'h0);
		@(posedge ref_clk);
		data_ecc_error <= 1'b1;
		expect_trap(1'b1, 3'h4, 8'h06, 2'h2);
		@(posedge ref_clk);
		{older_trap_pending, fetch_bus_error} <= 2'b11;
		expect_trap(1'b0, 3'h0, 8'h00, 2'h0);
		$display("test sync done");
	endtask

	task automatic t_misc;
		logic [31:0] q;
		logic e;
		@(posedge ref_clk);
		trap_on_overflow_instr <= 1'b1;
		expect_trap(1'b0, 3'h0, 8'h00, 2'h0);
		@(posedge ref_clk);
		{trap_on_overflow_instr, status_overflow_flag} <= 2'b11;
		expect_trap(1'b1, 3'h5, 8'h01, 2'h2);
		@(posedge ref_clk);
		{trap_on_overflow_instr, status_overflow_flag} <= 2'b11;
		{trap_on_sticky_overflow_instr, status_sticky_overflow_flag} <= 2'b11;
		expect_trap(1'b1, 3'h5, 8'h02, 2'h2);
		@(posedge ref_clk);
		{system_call_instr, system_call_imm} <= {1'b1, 8'ha5};
		data_load_bus_error <= 1'b1;
		expect_trap(1'b1, 3'h6, 8'ha5, 2'h2);
		check("d15_write", 32'h1, 32'(d15_write));
		check("d15_value", 32'ha5, 32'(d15_value));
		@(posedge ref_clk);
		{context_save_req, free_context_pointer, err_req} <= {1'b1, 32'h0, 6'h20};
		expect_trap(1'b1, 3'h3, 8'h04, 2'h0);
		@(posedge ref_clk);
		context_save_req <= 1'b1;
		expect_trap(1'b0, 3'h0, 8'h00, 2'h0);
		@(posedge ref_clk);
		debug_break_req <= 1'b1;
		expect_trap(1'b0, 3'h0, 8'h00, 2'h0);
		check("debug_trap", 32'h1, 32'(debug_trap));
		@(posedge ref_clk);
		{irq_request, fetch_bus_error} <= 2'b11;
		expect_trap(1'b1, 3'h4, 8'h01, 2'h2);
		check("irq_take", 32'h0, 32'(irq_take));
		@(posedge ref_clk);
		irq_request <= 1'b1;
		@(posedge ref_clk);
		clr();
		#1;
		check("irq_take", 32'h1, 32'(irq_take));
		check("trap_kind", 32'h3, 32'(trap_kind));
		wb(32'hc, 1'b0, 32'h0, 4'hf, q, e);
		check("status", 32'h00000401, q);
		wb(32'h10, 1'b0, 32'h0, 4'hf, q, e);
		check("last vector", vec_base_exp | 32'h00000080, q);
		$display("test misc done");
	endtask

	initial
	begin
		repeat (5000) @(posedge ref_clk);
		miscompares++;
		tally_and_finish();
	end

	initial
	begin
		vec_base_exp = 32'ha0000100;
		repeat (20) @(posedge ref_clk);
		rst <= 1'b0;
		instr_valid <= 1'b1;
		free_context_pointer <= 32'h00000100;
		t_regs();
		t_async();
		t_sync();
		t_misc();
		tally_and_finish();
	end
endmodule
`default_nettype wire
